// ### rtl/ucb_pkg.sv
// shared constants and types for the uart channel with baud generator
package ucb_pkg;
  localparam int          CLK_HZ          = 125_000_000;
  localparam int          TIMEOUT_STEP_MS = 1;
  localparam int          CYC_PER_STEP    = CLK_HZ / 1000 * TIMEOUT_STEP_MS;
  localparam logic [14:0] DIV_MIN         = 15'h0002;
  localparam logic [14:0] DIV_MAX         = 15'h4000;
  localparam logic [14:0] BAUD_CNT_RST    = 15'h0002;
  localparam logic [3:0]  OS_LAST         = 4'hF;
  localparam logic [3:0]  OS_MID          = 4'h7;
  localparam int          TXBUF_DEPTH     = 128;
  localparam int          RXBUF_DEPTH     = 384;
  localparam int          RX_HIGH_MARK    = 352;
  localparam int          RX_LOW_MARK     = 128;
  localparam int          PIN_W           = 14;
  localparam logic [13:0] PIN_RST         = 14'h3FFF;
  localparam int          PIN_RXD         = 8;
  localparam int          PIN_CTS         = 9;
  localparam int          PIN_DSR         = 10;
  localparam int          PIN_SI          = 13;

  typedef enum logic [1:0] {
    MODE_SERIAL   = 2'b00,
    MODE_ASYNC_BB = 2'b01,
    MODE_SYNC_BB  = 2'b10
  } ucb_mode_t;

  typedef enum logic [2:0] {
    PAR_NONE  = 3'b000,
    PAR_ODD   = 3'b001,
    PAR_EVEN  = 3'b010,
    PAR_MARK  = 3'b011,
    PAR_SPACE = 3'b100
  } ucb_par_t;

  typedef enum logic [1:0] {
    FLOW_NONE     = 2'b00,
    FLOW_RTS_CTS  = 2'b01,
    FLOW_DTR_DSR  = 2'b10,
    FLOW_XON_XOFF = 2'b11
  } ucb_flow_t;

  typedef enum logic [2:0] {
    SER_IDLE  = 3'b000,
    SER_START = 3'b001,
    SER_DATA  = 3'b010,
    SER_PAR   = 3'b011,
    SER_STOP  = 3'b100
  } ucb_ser_t;
endpackage

// ### rtl/ucb_strm_if.sv
// valid/ready byte stream between the channel and its output buffer
`timescale 1ns/1ps
interface ucb_strm_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ### rtl/ucb_skid.sv
// two-entry buffer; ready and output come straight from flops
`timescale 1ns/1ps
module ucb_skid #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic   clock,
  input  wire logic   reset_n,
  input  wire logic   clk_en,
  // filling and draining sides
  ucb_strm_if.snk     in_s,
  ucb_strm_if.src     out_s
);
  logic [W-1:0] d0_r;
  logic [W-1:0] d1_r;
  logic         v0_r;
  logic         v1_r;
  wire          push_w;
  wire          pop_w;

  assign push_w      = in_s.valid & ~v1_r;
  assign pop_w       = v0_r & out_s.ready;
  assign in_s.ready  = ~v1_r;
  assign out_s.valid = v0_r;
  assign out_s.data  = d0_r;

  // a stalled drain parks the second word in d1 instead of losing it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      d0_r <= '0;
      d1_r <= '0;
      v0_r <= 1'b0;
      v1_r <= 1'b0;
    end else if (clk_en) begin
      if (pop_w || !v0_r) begin
        if (v1_r) begin
          d0_r <= d1_r;
          v0_r <= 1'b1;
          v1_r <= 1'b0;
        end else begin
          d0_r <= in_s.data;
          v0_r <= push_w;
        end
      end else if (push_w) begin
        d1_r <= in_s.data;
        v1_r <= 1'b1;
      end
    end
  end

  skid_order_a: assert property (@(posedge clock) disable iff (!reset_n)
    v1_r |-> v0_r) else $error("spare entry filled while head empty");
endmodule

// ### rtl/ucb_channel.sv
// uart / bit-bang channel controller with fractional baud generator
`timescale 1ns/1ps
module ucb_channel #(
  parameter int TX_DEPTH     = ucb_pkg::TXBUF_DEPTH,
  parameter int RX_DEPTH     = ucb_pkg::RXBUF_DEPTH,
  parameter int CYC_PER_MS_P = ucb_pkg::CYC_PER_STEP
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  // configuration
  input  wire ucb_pkg::ucb_mode_t mode,
  input  wire logic [13:0]       div_int,
  input  wire logic [2:0]        div_frac,
  input  wire logic              seven_bit,
  input  wire ucb_pkg::ucb_par_t parity,
  input  wire logic              two_stop,
  input  wire ucb_pkg::ucb_flow_t flow,
  input  wire logic [7:0]        xon_char,
  input  wire logic [7:0]        xoff_char,
  input  wire logic              break_tx,
  input  wire logic [7:0]        timeout_ms,
  input  wire logic              rts_set,
  input  wire logic              dtr_set,
  input  wire logic [7:0]        bb_dir,
  // usb out endpoint
  input  wire logic [7:0]        tx_data,
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  // usb in endpoint
  output logic [7:0]             rx_data,
  output logic                   rx_valid,
  input  wire logic              rx_ready,
  output logic                   rx_release,
  // serial pins
  input  wire logic              rxd,
  input  wire logic              cts_n,
  input  wire logic              dsr_n,
  input  wire logic              dcd_n,
  input  wire logic              ri_n,
  output logic                   txd,
  output logic                   rts_n,
  output logic                   dtr_n,
  output logic                   rs485_drive_enable,
  // bit-bang pins
  input  wire logic [7:0]        bb_in,
  output logic [7:0]             bb_out,
  output logic [7:0]             bb_oe,
  output logic                   rd_strobe_n,
  output logic                   wr_strobe_n,
  // send immediate strobe
  input  wire logic              send_now_or_wakeup_n,
  // status
  output logic [3:0]             modem_status,
  output logic                   line_break,
  output logic                   frame_error,
  output logic                   parity_error,
  output logic                   rx_overrun
);
  import ucb_pkg::*;
  localparam int TXA = $clog2(TX_DEPTH);
  localparam int RXA = $clog2(RX_DEPTH);
  localparam int MSW = $clog2(CYC_PER_MS_P + 1);

  function automatic logic par_bit(input logic [7:0] d, input logic sev,
                                   input ucb_par_t p);
    logic x;
    x = ^(sev ? {1'b0, d[6:0]} : d);
    case (p)
      PAR_ODD:  par_bit = ~x;
      PAR_EVEN: par_bit = x;
      PAR_MARK: par_bit = 1'b1;
      default:  par_bit = 1'b0;
    endcase
  endfunction

  // pin synchronisers: a change counts once stages two and three agree
  wire logic [PIN_W-1:0] pin_raw = {send_now_or_wakeup_n, ri_n, dcd_n,
                                    dsr_n, cts_n, rxd, bb_in};
  logic [PIN_W-1:0] s1_r, s2_r, s3_r, pin_r;
  genvar g;
  generate
    for (g = 0; g < PIN_W; g++) begin : g_sync
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          s1_r[g]  <= PIN_RST[g];
          s2_r[g]  <= PIN_RST[g];
          s3_r[g]  <= PIN_RST[g];
          pin_r[g] <= PIN_RST[g];
        end else if (clk_en) begin
          s1_r[g] <= pin_raw[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          if (s2_r[g] == s3_r[g]) pin_r[g] <= s3_r[g];
        end
      end
    end
  endgenerate
  wire rxd_s = pin_r[PIN_RXD];

  // fractional baud generator: period n, plus one cycle per carry of eighths
  logic [14:0] cnt_r;
  logic [2:0]  frac_r;
  logic        tick_r;
  logic [3:0]  os_r;
  wire  [14:0] n_eff = (div_int == 14'h0000) ? DIV_MAX :
                       (div_int < 14'h0002) ? DIV_MIN : {1'b0, div_int};
  wire  [3:0]  frac_sum = {1'b0, frac_r} + {1'b0, div_frac};
  wire         reload = (cnt_r == 15'h0001);
  wire         bit_tick = tick_r && (os_r == OS_LAST);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r  <= BAUD_CNT_RST;
      frac_r <= 3'h0;
      tick_r <= 1'b0;
      os_r   <= 4'h0;
    end else if (clk_en) begin
      tick_r <= reload;
      cnt_r  <= reload ? n_eff + {14'h0000, frac_sum[3]} : cnt_r - 15'h0001;
      if (reload) frac_r <= frac_sum[2:0];
      if (tick_r) os_r <= os_r + 4'h1;
    end
  end

  // transmit buffer
  logic [7:0]   tx_mem [TX_DEPTH];
  logic [TXA-1:0] tx_wp_r, tx_rp_r;
  logic [TXA:0]   tx_cnt_r;
  wire push_tx = tx_valid && tx_ready;
  wire pop_tx;
  wire have_tx = (tx_cnt_r != '0);
  wire [TXA:0] tx_cnt_nxt = tx_cnt_r + (TXA+1)'(push_tx) - (TXA+1)'(pop_tx);
  wire [TXA-1:0] tx_wp_inc = (tx_wp_r == TXA'(TX_DEPTH-1)) ? '0 : tx_wp_r + 1'b1;
  wire [TXA-1:0] tx_rp_inc = (tx_rp_r == TXA'(TX_DEPTH-1)) ? '0 : tx_rp_r + 1'b1;
  always_ff @(posedge clock) begin
    if (clk_en && push_tx) tx_mem[tx_wp_r] <= tx_data;
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_wp_r  <= '0;
      tx_rp_r  <= '0;
      tx_cnt_r <= '0;
      tx_ready <= 1'b0;
    end else if (clk_en) begin
      if (push_tx) tx_wp_r <= tx_wp_inc;
      if (pop_tx) tx_rp_r <= tx_rp_inc;
      tx_cnt_r <= tx_cnt_nxt;
      tx_ready <= (tx_cnt_nxt != (TXA+1)'(TX_DEPTH));
    end
  end

  // receive buffer
  logic [7:0]   rx_mem [RX_DEPTH];
  logic [RXA-1:0] rx_wp_r, rx_rp_r;
  logic [RXA:0]   rx_cnt_r;
  logic         pause_r, sent_pause_r, remote_pause_r;
  ucb_strm_if #(.W(8)) fin ();
  ucb_strm_if #(.W(8)) fout ();
  wire         push_v;
  wire  [7:0]  push_d;
  wire         rx_full = (rx_cnt_r == (RXA+1)'(RX_DEPTH));
  wire         rx_wr = push_v && !rx_full;
  wire         rx_rd = fin.valid && fin.ready;
  wire [RXA-1:0] rx_wp_inc = (rx_wp_r == RXA'(RX_DEPTH-1)) ? '0 : rx_wp_r + 1'b1;
  wire [RXA-1:0] rx_rp_inc = (rx_rp_r == RXA'(RX_DEPTH-1)) ? '0 : rx_rp_r + 1'b1;
  assign fin.valid  = (rx_cnt_r != '0);
  assign fin.data   = rx_mem[rx_rp_r];
  assign fout.ready = rx_ready;
  assign rx_data    = fout.data;
  assign rx_valid   = fout.valid;
  always_ff @(posedge clock) begin
    if (clk_en && rx_wr) rx_mem[rx_wp_r] <= push_d;
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_wp_r    <= '0;
      rx_rp_r    <= '0;
      rx_cnt_r   <= '0;
      rx_overrun <= 1'b0;
      pause_r    <= 1'b0;
    end else if (clk_en) begin
      if (rx_wr) rx_wp_r <= rx_wp_inc;
      if (rx_rd) rx_rp_r <= rx_rp_inc;
      rx_cnt_r <= rx_cnt_r + (RXA+1)'(rx_wr) - (RXA+1)'(rx_rd);
      if (push_v && rx_full) rx_overrun <= 1'b1;
      // hysteresis keeps the far end from toggling per byte
      if (rx_cnt_r >= (RXA+1)'(RX_HIGH_MARK)) pause_r <= 1'b1;
      else if (rx_cnt_r <= (RXA+1)'(RX_LOW_MARK)) pause_r <= 1'b0;
    end
  end
  ucb_skid #(.W(8)) u_skid (
    .clock   (clock),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .in_s    (fin),
    .out_s   (fout)
  );

  // serial transmitter
  ucb_ser_t   tx_st_r;
  logic [7:0] tx_sh_r;
  logic [3:0] tx_sub_r;
  logic [2:0] tx_bit_r;
  logic       tx_par_r, tx_stop2_r;
  wire ser_mode = (mode == MODE_SERIAL);
  wire bb_mode  = (mode == MODE_ASYNC_BB) || (mode == MODE_SYNC_BB);
  wire ctrl_pend = (flow == FLOW_XON_XOFF) && (pause_r != sent_pause_r);
  wire flow_ok = (flow == FLOW_RTS_CTS) ? !pin_r[PIN_CTS] :
                 (flow == FLOW_DTR_DSR) ? !pin_r[PIN_DSR] :
                 (flow == FLOW_XON_XOFF) ? !remote_pause_r : 1'b1;
  wire tx_go = ser_mode && (tx_st_r == SER_IDLE) && tick_r && !break_tx &&
               (ctrl_pend || (have_tx && flow_ok));
  wire [7:0] tx_load = ctrl_pend ? (pause_r ? xoff_char : xon_char)
                                 : tx_mem[tx_rp_r];
  wire tx_adv = tick_r && (tx_sub_r == OS_LAST);
  wire [2:0] last_bit = seven_bit ? 3'h6 : 3'h7;
  wire bb_wr = bb_mode && bit_tick && have_tx;
  assign pop_tx = (tx_go && !ctrl_pend) || bb_wr;
  wire txd_nxt = break_tx ? 1'b0 :
                 (tx_st_r == SER_START) ? 1'b0 :
                 (tx_st_r == SER_DATA) ? tx_sh_r[0] :
                 (tx_st_r == SER_PAR) ? tx_par_r : 1'b1;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_st_r <= SER_IDLE;
      tx_sh_r <= 8'h00;
      tx_sub_r <= 4'h0;
      tx_bit_r <= 3'h0;
      tx_par_r <= 1'b0;
      tx_stop2_r <= 1'b0;
      sent_pause_r <= 1'b0;
    end else if (clk_en) begin
      if (tick_r) tx_sub_r <= (tx_st_r == SER_IDLE) ? 4'h0 : tx_sub_r + 4'h1;
      case (tx_st_r)
        SER_IDLE: if (tx_go) begin
          tx_st_r  <= SER_START;
          tx_sh_r  <= tx_load;
          tx_par_r <= par_bit(tx_load, seven_bit, parity);
          tx_stop2_r <= 1'b0;
          if (ctrl_pend) sent_pause_r <= pause_r;
        end
        SER_START: if (tx_adv) begin
          tx_st_r  <= SER_DATA;
          tx_bit_r <= 3'h0;
        end
        SER_DATA: if (tx_adv) begin
          tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
          tx_bit_r <= tx_bit_r + 3'h1;
          if (tx_bit_r == last_bit)
            tx_st_r <= (parity == PAR_NONE) ? SER_STOP : SER_PAR;
        end
        SER_PAR: if (tx_adv) tx_st_r <= SER_STOP;
        SER_STOP: if (tx_adv) begin
          if (two_stop && !tx_stop2_r) tx_stop2_r <= 1'b1;
          else tx_st_r <= SER_IDLE;
        end
        default: tx_st_r <= SER_IDLE;
      endcase
    end
  end

  // serial receiver, sampled at mid-bit
  ucb_ser_t   rx_st_r;
  logic [7:0] rx_sh_r;
  logic [3:0] rx_sub_r;
  logic [2:0] rx_bit_r;
  logic       rx_armed_r, rx_perr_r;
  wire rx_mid = tick_r && (rx_sub_r == OS_MID);
  wire rx_end = tick_r && (rx_sub_r == OS_LAST);
  wire [7:0] rx_byte = seven_bit ? {1'b0, rx_sh_r[7:1]} : rx_sh_r;
  wire rx_done = ser_mode && (rx_st_r == SER_STOP) && rx_mid;
  wire rx_brk  = !rxd_s && (rx_byte == 8'h00);
  wire rx_good = rx_done && rxd_s;
  wire is_fc   = (flow == FLOW_XON_XOFF) &&
                 ((rx_byte == xon_char) || (rx_byte == xoff_char));
  wire ser_push = rx_good && !is_fc;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_st_r <= SER_IDLE;
      rx_sh_r <= 8'h00;
      rx_sub_r <= 4'h0;
      rx_bit_r <= 3'h0;
      rx_armed_r <= 1'b0;
      rx_perr_r <= 1'b0;
    end else if (clk_en) begin
      if (tick_r) rx_sub_r <= rx_sub_r + 4'h1;
      case (rx_st_r)
        SER_IDLE: begin
          // re-arm only on a high line so a held break counts once
          if (tick_r && rxd_s) rx_armed_r <= 1'b1;
          if (tick_r && rx_armed_r && !rxd_s && ser_mode) begin
            rx_st_r <= SER_START;
            rx_sub_r <= 4'h1;
            rx_armed_r <= 1'b0;
          end
        end
        SER_START: if (rx_mid && rxd_s) rx_st_r <= SER_IDLE;
                   else if (rx_end) begin
                     rx_st_r <= SER_DATA;
                     rx_bit_r <= 3'h0;
                   end
        SER_DATA: begin
          if (rx_mid) rx_sh_r <= {rxd_s, rx_sh_r[7:1]};
          if (rx_end) begin
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_bit_r == last_bit)
              rx_st_r <= (parity == PAR_NONE) ? SER_STOP : SER_PAR;
          end
        end
        SER_PAR: begin
          if (rx_mid) rx_perr_r <= rxd_s != par_bit(rx_byte, seven_bit, parity);
          if (rx_end) rx_st_r <= SER_STOP;
        end
        SER_STOP: if (rx_mid) rx_st_r <= SER_IDLE;
        default: rx_st_r <= SER_IDLE;
      endcase
    end
  end

  // bit-bang port, modem lines, status
  wire bb_rd = ((mode == MODE_SYNC_BB) && bb_wr) ||
               ((mode == MODE_ASYNC_BB) && bit_tick && !fin.valid);
  assign push_v = ser_push || bb_rd;
  assign push_d = bb_rd ? pin_r[7:0] : rx_byte;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      txd <= 1'b1;
      rs485_drive_enable <= 1'b0;
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
      bb_out <= 8'h00;
      bb_oe <= 8'h00;
      rd_strobe_n <= 1'b1;
      wr_strobe_n <= 1'b1;
      modem_status <= 4'h0;
      remote_pause_r <= 1'b0;
      line_break <= 1'b0;
      frame_error <= 1'b0;
      parity_error <= 1'b0;
    end else if (clk_en) begin
      txd <= txd_nxt;
      rs485_drive_enable <= (tx_st_r != SER_IDLE);
      rts_n <= (flow == FLOW_RTS_CTS) ? pause_r : !rts_set;
      dtr_n <= (flow == FLOW_DTR_DSR) ? pause_r : !dtr_set;
      modem_status <= ~pin_r[12:9];
      if (bb_wr) bb_out <= tx_mem[tx_rp_r];
      bb_oe <= bb_mode ? bb_dir : 8'h00;
      wr_strobe_n <= !bb_wr;
      rd_strobe_n <= !bb_rd;
      if (rx_good && is_fc) remote_pause_r <= (rx_byte == xoff_char);
      if (rx_done && rx_brk) line_break <= 1'b1;
      else if (rx_good) line_break <= 1'b0;
      if (rx_done && !rxd_s && !rx_brk) frame_error <= 1'b1;
      else if (rx_good) frame_error <= 1'b0;
      if (rx_good) parity_error <= rx_perr_r && (parity != PAR_NONE);
    end
  end

  // release timer and send-now strobe
  logic [MSW-1:0] ms_cnt_r;
  logic [7:0]     tout_r;
  logic           si_q_r;
  wire ms_tick  = (ms_cnt_r == MSW'(CYC_PER_MS_P - 1));
  wire [7:0] tlim = (timeout_ms == 8'h00) ? 8'h01 : timeout_ms;
  wire pending  = fin.valid || fout.valid;
  wire si_fall  = si_q_r && !pin_r[PIN_SI];
  wire rel_set  = pending && (si_fall || (tout_r == tlim));
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ms_cnt_r <= '0;
      tout_r <= 8'h00;
      si_q_r <= 1'b1;
      rx_release <= 1'b0;
    end else if (clk_en) begin
      si_q_r <= pin_r[PIN_SI];
      ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 1'b1;
      if (rx_wr || !pending) tout_r <= 8'h00;
      else if (ms_tick && tout_r != tlim) tout_r <= tout_r + 8'h01;
      if (rel_set) rx_release <= 1'b1;
      else if (!pending) rx_release <= 1'b0;
    end
  end

  baud_reload_a: assert property (@(posedge clock)
    disable iff (!reset_n || !clk_en) reload |=> (tick_r &&
      cnt_r >= DIV_MIN && cnt_r <= DIV_MAX + 15'h0001))
    else $error("baud reload out of range");
  baud_gap_a: assert property (@(posedge clock)
    disable iff (!reset_n || !clk_en) tick_r |=> !tick_r)
    else $error("baud ticks back to back");
  txbuf_bound_a: assert property (@(posedge clock)
    disable iff (!reset_n) tx_cnt_r <= (TXA+1)'(TX_DEPTH))
    else $error("tx buffer count over depth");
  rxbuf_bound_a: assert property (@(posedge clock)
    disable iff (!reset_n) rx_cnt_r <= (RXA+1)'(RX_DEPTH))
    else $error("rx buffer count over depth");
  start_low_a: assert property (@(posedge clock)
    disable iff (!reset_n || !clk_en) (tx_st_r == SER_START) |=> !txd)
    else $error("start bit not low");
  drive_en_a: assert property (@(posedge clock)
    disable iff (!reset_n || !clk_en)
    $rose(tx_st_r == SER_START) |=> rs485_drive_enable [*2])
    else $error("rs485 enable not high during frame");
  cts_gate_a: assert property (@(posedge clock)
    disable iff (!reset_n) (tx_go && flow == FLOW_RTS_CTS && !ctrl_pend)
    |-> !pin_r[PIN_CTS]) else $error("sent while cts deasserted");
  break_line_a: assert property (@(posedge clock)
    disable iff (!reset_n || !clk_en) break_tx |=> !txd)
    else $error("break not forced on txd");
  sync_pair_a: assert property (@(posedge clock)
    disable iff (!reset_n || !clk_en) (mode == MODE_SYNC_BB && bb_wr)
    |=> (!wr_strobe_n && !rd_strobe_n)) else $error("sync read not paired");
  strobe_pulse_a: assert property (@(posedge clock)
    disable iff (!reset_n || !clk_en) $fell(wr_strobe_n) |=> wr_strobe_n)
    else $error("write strobe longer than one cycle");
  send_now_a: assert property (@(posedge clock)
    disable iff (!reset_n || !clk_en) (si_fall && pending) |=> rx_release)
    else $error("send-now did not release data");
endmodule

// ### tb/ucb_serial_peer.sv
// far-end serial model: frames bytes onto rxd, decodes txd
`timescale 1ns/1ps
module ucb_serial_peer #(
  parameter real BIT_NS = 448.0
) (
  input wire logic txd,
  output logic     rxd
);
  logic [7:0] got_q[$];
  initial rxd = 1'b1;
  // start low, lsb first, high stop held for two bit times
  task automatic send(input logic [7:0] b);
    rxd = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      rxd = b[i];
      #(BIT_NS);
    end
    rxd = 1'b1;
    #(2.0 * BIT_NS);
  endtask
  // sample mid-bit; a frame without a high stop is dropped
  always @(negedge txd) begin : dec
    logic [7:0] b;
    #(BIT_NS / 2.0);
    if (txd === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        #(BIT_NS);
        b[i] = txd;
      end
      #(BIT_NS);
      if (txd === 1'b1) got_q.push_back(b);
    end
  end
endmodule

// ### tb/usb_uart_channel_baud_gen_tb.sv
// self-checking bench for the uart channel
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("mismatch %0t got %h exp %h", $time, a, e); end end
module usb_uart_channel_baud_gen_tb;
  import ucb_pkg::*;
  logic clock, reset_n, clk_en, seven_bit, two_stop, break_tx, rts_set;
  logic dtr_set, tx_valid, tx_ready, rx_valid, rx_ready, rx_release, rxd;
  logic cts_n, dsr_n, dcd_n, ri_n, txd, rts_n, dtr_n, rs485_drive_enable;
  logic rd_strobe_n, wr_strobe_n, send_now_or_wakeup_n, line_break;
  logic frame_error, parity_error, rx_overrun;
  logic [13:0] div_int;
  logic [2:0] div_frac;
  logic [7:0] xon_char, xoff_char, timeout_ms, bb_dir, tx_data, rx_data;
  logic [7:0] bb_in, bb_out, bb_oe;
  logic [3:0] modem_status;
  ucb_mode_t mode;
  ucb_par_t parity;
  ucb_flow_t flow;
  int fail_count, num_checks, cyc;
  logic [7:0] pat[4] = '{8'hA5, 8'h3C, 8'h80, 8'h01};
  ucb_channel #(.TX_DEPTH(4), .CYC_PER_MS_P(50)) dut (.clock, .reset_n,
    .clk_en, .mode, .div_int, .div_frac, .seven_bit, .parity, .two_stop,
    .flow, .xon_char, .xoff_char, .break_tx, .timeout_ms, .rts_set,
    .dtr_set, .bb_dir, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid,
    .rx_ready, .rx_release, .rxd, .cts_n, .dsr_n, .dcd_n, .ri_n, .txd,
    .rts_n, .dtr_n, .rs485_drive_enable, .bb_in, .bb_out, .bb_oe,
    .rd_strobe_n, .wr_strobe_n, .send_now_or_wakeup_n, .modem_status,
    .line_break, .frame_error, .parity_error, .rx_overrun);
  // 3.5 divisor: 56 clocks per bit
  ucb_serial_peer #(.BIT_NS(448.0)) peer (.txd, .rxd);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, well above the few thousand cycles needed
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      stop_test();
    end
  end
  // caller lowers tx_valid itself so back-to-back pushes stay clean
  task automatic put(input logic [7:0] b);
    tx_data <= b;
    tx_valid <= 1'b1;
    do @(posedge clock); while (tx_ready !== 1'b1);
  endtask
  task automatic take(input logic [7:0] e);
    do @(posedge clock); while (rx_valid !== 1'b1);
    `CHK(rx_data, e)
  endtask
  initial begin
    {clk_en, reset_n, rts_set, dtr_set, cts_n, dsr_n} = 6'b101111;
    {seven_bit, two_stop, break_tx, tx_valid, rx_ready} = 5'h00;
    {dcd_n, ri_n, send_now_or_wakeup_n} = 3'b111;
    mode = MODE_SERIAL;
    parity = PAR_NONE;
    flow = FLOW_RTS_CTS;
    div_int = 14'h0003;
    div_frac = 3'h4;
    {xon_char, xoff_char, timeout_ms} = {8'h11, 8'h13, 8'h05};
    {bb_dir, tx_data, bb_in} = 24'h000000;
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    `CHK(txd, 1'b1)
    // remote paused: queue fills and refuses, nothing leaves
    for (int i = 0; i < 4; i++) put(pat[i]);
    tx_valid <= 1'b0;
    repeat (3) @(posedge clock);
    `CHK(tx_ready, 1'b0)
    `CHK(txd, 1'b1)
    cts_n <= 1'b0;
    @(negedge txd);
    #1 `CHK(rs485_drive_enable, 1'b1)
    while (peer.got_q.size() < 4) @(posedge clock);
    for (int i = 0; i < 4; i++) `CHK(peer.got_q[i], pat[i])
    @(posedge clock) dcd_n <= 1'b0;
    repeat (8) @(posedge clock);
    `CHK(modem_status, 4'h5)
    `CHK({rts_n, dtr_n}, 2'b00)
    $display("test tx done");
    // receiver stalled while two bytes arrive, then drained in order
    peer.send(8'h5A);
    peer.send(8'hC3);
    `CHK(rx_release, 1'b1)
    @(posedge clock) rx_ready <= 1'b1;
    take(8'h5A);
    take(8'hC3);
    repeat (2) @(posedge clock);
    `CHK(rx_release, 1'b0)
    $display("test rx done");
    // a line held low past a whole frame reads as break, not as data
    peer.rxd <= 1'b0;
    repeat (700) @(posedge clock);
    peer.rxd <= 1'b1;
    `CHK(line_break, 1'b1)
    rx_ready <= 1'b0;
    repeat (60) @(posedge clock);
    // send-now flushes a byte long before the release timeout
    peer.send(8'h77);
    `CHK(rx_release, 1'b0)
    @(posedge clock) send_now_or_wakeup_n <= 1'b0;
    repeat (4) @(posedge clock);
    send_now_or_wakeup_n <= 1'b1;
    repeat (4) @(posedge clock);
    `CHK(rx_release, 1'b1)
    `CHK(line_break, 1'b0)
    rx_ready <= 1'b1;
    take(8'h77);
    $display("test release done");
    break_tx <= 1'b1;
    repeat (4) @(posedge clock);
    `CHK(txd, 1'b0)
    break_tx <= 1'b0;
    $display("test break done");
    // sync bit-bang: one pin sample per written byte
    mode <= MODE_SYNC_BB;
    {bb_dir, bb_in} <= 16'hFF6C;
    repeat (8) @(posedge clock);
    put(8'h9E);
    tx_valid <= 1'b0;
    do @(posedge clock); while (wr_strobe_n !== 1'b0);
    `CHK(rd_strobe_n, 1'b0)
    `CHK(bb_out, 8'h9E)
    `CHK(bb_oe, 8'hFF)
    take(8'h6C);
    `CHK({rx_overrun, parity_error, frame_error}, 3'b000)
    $display("test bitbang done");
    stop_test();
  end
endmodule
